// ### src/opc_output_port.v
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`include "opc_regs.vh"
module opc_output_port (
  input wire CORE_CLK,
  input wire ARST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire [5:0] SRC_VALID,
  input wire [95:0] SRC_I,
  input wire [95:0] SRC_Q,
  input wire [11:0] GAIN_A_SIGNAL_STRENGTH_WORD,
  input wire [11:0] GAIN_B_SIGNAL_STRENGTH_WORD,
  output wire OUT_VALID,
  input wire OUT_READY,
  output wire [15:0] OUT_DATA,
  output wire OUT_IQ,
  output wire [2:0] OUT_CHAN,
  output wire OUT_LINK,
  output wire PORT_A_LINK_EN,
  output wire PORT_B_LINK_EN,
  input wire PORT_CLK_IN,
  output wire PORT_CLK_OUT,
  output wire PORT_CLK_OE_N
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SEND = 2'h2;

  reg [7:0] link_a;
  reg [7:0] link_b;
  reg [5:0] par_b;
  reg [2:0] pclk_ctl;
  reg [5:0] pend;
  reg [15:0] hold_i [0:5];
  reg [15:0] hold_q [0:5];
  reg [11:0] signal_strength_word_a;
  reg [11:0] signal_strength_word_b;
  reg [1:0] st;
  reg [2:0] link_src;
  reg [3:0] wait_cnt;
  reg [4:0] elem;
  reg [2:0] w_src;
  reg [15:0] w_i;
  reg [15:0] w_q;
  reg [11:0] w_signal_strength_word;
  reg w_link;
  reg w_signal_strength_word_on;
  reg w_pack;
  reg [5:0] consume;
  reg [15:0] elem_data;
  reg elem_iq;
  reg [4:0] elem_last;
  wire buf_ready;
  wire buf_valid;
  wire [20:0] buf_out;
  wire link_on;
  wire [5:0] par_allow;
  wire [3:0] par_pick;
  wire [3:0] dly_field;
  wire [3:0] dly;
  wire gain_signal_strength_word;
  wire wr_en;
  wire mapped;

  // ----------------------------------------------------------------
  // Helper decodes
  // ----------------------------------------------------------------
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `OPC_ADDR_LINK_A) || (a == `OPC_ADDR_PAR_B) ||
                (a == `OPC_ADDR_LINK_B) || (a == `OPC_ADDR_PCLK) ||
                (a == `OPC_ADDR_STATUS);
    end
  endfunction

  // Lowest pending enabled source; stands in for arrival order
  function [3:0] first_set;
    input [5:0] p;
    integer k;
    begin
      first_set = 4'h0;
      for (k = 5; k >= 0; k = k - 1) begin
        if (p[k]) begin
          first_set = {1'b1, k[2:0]};
        end
      end
    end
  endfunction

  function link_ok;
    input [2:0] cur;
    input [7:0] ctl;
    begin
      if (!ctl[`OPC_LNK_SRC]) begin
        link_ok = ctl[`OPC_LNK_MODE] ? (cur < 3'h4) : (cur < 3'h2);
      end else if (ctl[`OPC_LNK_MODE]) begin
        link_ok = (cur == `OPC_SRC_GAIN_B);
      end else begin
        link_ok = (cur == `OPC_SRC_GAIN_A) || (cur == `OPC_SRC_GAIN_B);
      end
    end
  endfunction

  function [2:0] link_next;
    input [2:0] cur;
    input [7:0] ctl;
    begin
      if (!ctl[`OPC_LNK_SRC]) begin
        if (ctl[`OPC_LNK_MODE]) begin
          link_next = (cur == 3'h3) ? 3'h0 : cur + 3'h1;
        end else begin
          link_next = (cur == 3'h0) ? 3'h1 : 3'h0;
        end
      end else if (ctl[`OPC_LNK_MODE]) begin
        link_next = `OPC_SRC_GAIN_B;
      end else begin
        link_next = (cur == `OPC_SRC_GAIN_A) ? `OPC_SRC_GAIN_B :
                    `OPC_SRC_GAIN_A;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign mapped = addr_ok(PADDR);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign wr_en = PSEL & PENABLE & PWRITE & mapped;

  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      link_a <= `OPC_RST_LINK;
      link_b <= `OPC_RST_LINK;
      par_b <= `OPC_RST_PAR;
      pclk_ctl <= `OPC_RST_PCLK;
    end else if (wr_en) begin
      case (PADDR)
        `OPC_ADDR_LINK_A: link_a <= PWDATA[7:0];
        `OPC_ADDR_PAR_B: par_b <= PWDATA[5:0];
        `OPC_ADDR_LINK_B: link_b <= PWDATA[7:0];
        `OPC_ADDR_PCLK: pclk_ctl <= PWDATA[2:0];
        default: ;
      endcase
    end
  end

  // Read data is latched in the setup cycle so it is a flop output
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      case (PADDR)
        `OPC_ADDR_LINK_A: PRDATA <= {24'h000000, link_a};
        `OPC_ADDR_PAR_B: PRDATA <= {26'h0000000, par_b};
        `OPC_ADDR_LINK_B: PRDATA <= {24'h000000, link_b};
        `OPC_ADDR_PCLK: PRDATA <= {29'h00000000, pclk_ctl};
        `OPC_ADDR_STATUS: PRDATA <= {20'h00000, PORT_CLK_IN, st,
                                     link_src, pend};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sample capture per source
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : cap
      always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          pend[g] <= 1'b0;
          hold_i[g] <= 16'h0000;
          hold_q[g] <= 16'h0000;
        end else begin
          // A new sample wins over the consume in the same cycle
          pend[g] <= (pend[g] & ~consume[g]) | SRC_VALID[g];
          if (SRC_VALID[g]) begin
            hold_i[g] <= SRC_I[16*g +: 16];
            hold_q[g] <= SRC_Q[16*g +: 16];
          end
        end
      end
    end
  endgenerate

  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      signal_strength_word_a <= 12'h000;
      signal_strength_word_b <= 12'h000;
    end else begin
      if (SRC_VALID[4]) begin
        signal_strength_word_a <= GAIN_A_SIGNAL_STRENGTH_WORD;
      end
      if (SRC_VALID[5]) begin
        signal_strength_word_b <= GAIN_B_SIGNAL_STRENGTH_WORD;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign link_on = link_b[`OPC_LNK_EN];
  assign PORT_A_LINK_EN = link_a[`OPC_LNK_EN];
  assign PORT_B_LINK_EN = link_on;
  assign par_allow = par_b[`OPC_PAR_SRC] ?
                     {par_b[2:1], 4'h0} :
                     {2'h0, par_b[`OPC_PAR_EN_HI:`OPC_PAR_EN_LO]};
  assign par_pick = first_set(pend & par_allow);
  assign dly_field = link_b[`OPC_LNK_DLY_HI:`OPC_LNK_DLY_LO];
  assign dly = (dly_field < `OPC_MIN_WAIT) ? `OPC_MIN_WAIT : dly_field;
  // Strength words only with gain data; bit 2 ignored otherwise
  assign gain_signal_strength_word = link_b[`OPC_LNK_SRC] &
                     (link_b[`OPC_LNK_MODE] | ~link_b[`OPC_LNK_NORSSI]);

  // ----------------------------------------------------------------
  // Word sequencer
  // ----------------------------------------------------------------
  always @* begin
    consume = 6'h00;
    if (st == ST_IDLE) begin
      if (link_on) begin
        if (link_ok(link_src, link_b) && pend[link_src]) begin
          consume[link_src] = 1'b1;
        end
      end else if (par_pick[3]) begin
        consume[par_pick[2:0]] = 1'b1;
      end
    end
  end

  always @* begin
    elem_data = 16'h0000;
    elem_iq = 1'b0;
    if (w_link) begin
      elem_last = w_signal_strength_word_on ? `OPC_SIGNAL_STRENGTH_WORD_LAST : `OPC_IQ_LAST;
      case (elem)
        5'h00: elem_data = {8'h00, w_i[7:0]};
        5'h01: elem_data = {8'h00, w_i[15:8]};
        5'h02: elem_data = {8'h00, w_q[7:0]};
        5'h03: elem_data = {8'h00, w_q[15:8]};
        5'h04: elem_data = {8'h00, w_signal_strength_word[3:0], 4'h0};
        5'h05: elem_data = {8'h00, w_signal_strength_word[11:4]};
        default: elem_data = 16'h0000;
      endcase
      elem_iq = (elem < 5'h02);
    end else begin
      elem_last = w_pack ? 5'h00 : 5'h01;
      if (w_pack) begin
        elem_data = {w_i[15:8], w_q[15:8]};
        elem_iq = 1'b1;
      end else begin
        elem_data = (elem == 5'h00) ? w_i : w_q;
        elem_iq = (elem == 5'h00);
      end
    end
  end

  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= ST_IDLE;
      link_src <= 3'h0;
      wait_cnt <= 4'h0;
      elem <= 5'h00;
      w_src <= 3'h0;
      w_i <= 16'h0000;
      w_q <= 16'h0000;
      w_signal_strength_word <= 12'h000;
      w_link <= 1'b0;
      w_signal_strength_word_on <= 1'b0;
      w_pack <= 1'b0;
    end else begin
      case (st)
        ST_IDLE: begin
          elem <= 5'h00;
          if (link_on) begin
            if (!link_ok(link_src, link_b)) begin
              link_src <= link_b[`OPC_LNK_SRC] ? `OPC_SRC_GAIN_B : 3'h0;
            end else if (pend[link_src]) begin
              w_src <= link_src;
              w_i <= hold_i[link_src];
              w_q <= hold_q[link_src];
              w_signal_strength_word <= (link_src == `OPC_SRC_GAIN_A) ? signal_strength_word_a : signal_strength_word_b;
              w_link <= 1'b1;
              w_signal_strength_word_on <= gain_signal_strength_word;
              wait_cnt <= dly;
              st <= ST_WAIT;
            end
          end else if (par_pick[3]) begin
            w_src <= par_pick[2:0];
            w_i <= hold_i[par_pick[2:0]];
            w_q <= hold_q[par_pick[2:0]];
            w_link <= 1'b0;
            w_signal_strength_word_on <= 1'b0;
            w_pack <= par_b[`OPC_PAR_PACK];
            st <= ST_SEND;
          end
        end
        ST_WAIT: begin
          wait_cnt <= wait_cnt - 4'h1;
          if (wait_cnt <= 4'h1) begin
            st <= ST_SEND;
          end
        end
        ST_SEND: begin
          // Holding here on a full buffer is the back-pressure path
          if (buf_ready) begin
            if (elem == elem_last) begin
              st <= ST_IDLE;
              if (w_link) begin
                link_src <= link_next(link_src, link_b);
              end
            end else begin
              elem <= elem + 5'h01;
            end
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output buffer and port clock
  // ----------------------------------------------------------------
  opc_pair_buf #(
    .WIDTH(21),
    .DEPTH(2),
    .AW(1)
  ) u_buf (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .in_valid(st == ST_SEND),
    .in_ready(buf_ready),
    .in_data({w_link, elem_iq, w_src, elem_data}),
    .out_valid(buf_valid),
    .out_ready(OUT_READY),
    .out_data(buf_out)
  );

  assign OUT_VALID = buf_valid;
  assign OUT_LINK = buf_out[20];
  assign OUT_IQ = buf_out[19];
  assign OUT_CHAN = buf_out[18:16];
  assign OUT_DATA = buf_out[15:0];

  opc_clk_div u_div (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .master(pclk_ctl[`OPC_PCLK_MASTER]),
    .div_code(pclk_ctl[`OPC_PCLK_DIV_HI:`OPC_PCLK_DIV_LO]),
    .port_clk(PORT_CLK_OUT),
    .port_clk_oe_n(PORT_CLK_OE_N)
  );
endmodule // opc_output_port

// ### src/opc_regs.vh
`ifndef OPC_REGS_VH
`define OPC_REGS_VH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define OPC_IDX_LINK_A 8'h1B
`define OPC_IDX_PAR_B 8'h1C
`define OPC_IDX_LINK_B 8'h1D
`define OPC_IDX_PCLK 8'h1E
`define OPC_IDX_STATUS 8'h1F
`define OPC_ADDR_LINK_A 8'h6C
`define OPC_ADDR_PAR_B 8'h70
`define OPC_ADDR_LINK_B 8'h74
`define OPC_ADDR_PCLK 8'h78
`define OPC_ADDR_STATUS 8'h7C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OPC_LNK_SRC 0
`define OPC_LNK_MODE 1
`define OPC_LNK_NORSSI 2
`define OPC_LNK_DLY_LO 3
`define OPC_LNK_DLY_HI 6
`define OPC_LNK_EN 7
`define OPC_PAR_SRC 0
`define OPC_PAR_EN_LO 1
`define OPC_PAR_EN_HI 4
`define OPC_PAR_PACK 5
`define OPC_PCLK_MASTER 0
`define OPC_PCLK_DIV_LO 1
`define OPC_PCLK_DIV_HI 2

// ----------------------------------------------------------------
// Reset values, counts
// ----------------------------------------------------------------
`define OPC_RST_LINK 8'h00
`define OPC_RST_PAR 6'h00
`define OPC_RST_PCLK 3'h0
`define OPC_MIN_WAIT 4'h6
`define OPC_IQ_LAST 5'h03
`define OPC_SIGNAL_STRENGTH_WORD_LAST 5'h13
`define OPC_SRC_GAIN_A 3'h4
`define OPC_SRC_GAIN_B 3'h5

`endif

// ### src/opc_pair_buf.v
`timescale 1ns/100ps
module opc_pair_buf #(
  parameter WIDTH = 21,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire clk,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; empty flag guards stale contents
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // opc_pair_buf

// ### src/opc_clk_div.v
`timescale 1ns/100ps
module opc_clk_div (
  input wire clk,
  input wire arst_n,
  input wire master,
  input wire [1:0] div_code,
  output wire port_clk,
  output wire port_clk_oe_n
);
  reg [2:0] cnt;
  wire [3:0] taps;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

  // Divide by one passes the device clock straight through
  assign taps = {cnt, clk};
  assign port_clk = taps[div_code];
  assign port_clk_oe_n = ~master;
endmodule // opc_clk_div

// ### verification/opc_output_port_asserts.sv
`timescale 1ns/100ps
`include "opc_regs.vh"
module opc_output_port_asserts (
  input wire CORE_CLK,
  input wire ARST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire OUT_VALID,
  input wire OUT_READY,
  input wire [15:0] OUT_DATA,
  input wire OUT_IQ,
  input wire [2:0] OUT_CHAN,
  input wire OUT_LINK,
  input wire PORT_A_LINK_EN,
  input wire PORT_B_LINK_EN,
  input wire PORT_CLK_OE_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  wire acc = PSEL && PENABLE;
  wire b_wr = acc && PWRITE && PADDR == `OPC_ADDR_LINK_B;
  wire mapped = PADDR >= `OPC_ADDR_LINK_A && PADDR <= `OPC_ADDR_STATUS
    && PADDR[1:0] == 2'h0;
  sequence s_wr(a);
    acc && PWRITE && PADDR == a;
  endsequence
  sequence s_hold;
    OUT_VALID && $stable(OUT_DATA) && $stable(OUT_CHAN)
      && $stable(OUT_IQ) && $stable(OUT_LINK);
  endsequence
  chk_ready_high: assert property (PSEL |-> PREADY)
    else $error("pready low while selected");
  chk_unmapped_err: assert property (acc && !mapped |-> PSLVERR)
    else $error("no error on unmapped address");
  chk_mapped_ok: assert property (acc && mapped |-> !PSLVERR)
    else $error("error on mapped address");
  chk_link_a_en: assert property (
    s_wr(`OPC_ADDR_LINK_A) |=> PORT_A_LINK_EN == $past(PWDATA[7]))
    else $error("port A link enable wrong");
  chk_link_b_en: assert property (
    s_wr(`OPC_ADDR_LINK_B) |=> PORT_B_LINK_EN == $past(PWDATA[7]))
    else $error("port B link enable wrong");
  chk_b_en_cause: assert property (
    $changed(PORT_B_LINK_EN) |-> $past(b_wr))
    else $error("port B link enable moved without write");
  chk_clk_master: assert property (
    s_wr(`OPC_ADDR_PCLK) |=> PORT_CLK_OE_N == !$past(PWDATA[0]))
    else $error("port clock drive enable wrong");
  chk_stall_hold: assert property (OUT_VALID && !OUT_READY |=> s_hold)
    else $error("output changed while stalled");
  chk_link_byte: assert property (
    OUT_VALID && OUT_LINK |-> OUT_DATA[15:8] == 8'h00)
    else $error("link element wider than a byte");
endmodule // opc_output_port_asserts

bind opc_output_port opc_output_port_asserts u_chk (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
  .OUT_DATA(OUT_DATA), .OUT_IQ(OUT_IQ), .OUT_CHAN(OUT_CHAN),
  .OUT_LINK(OUT_LINK), .PORT_A_LINK_EN(PORT_A_LINK_EN),
  .PORT_B_LINK_EN(PORT_B_LINK_EN), .PORT_CLK_OE_N(PORT_CLK_OE_N)
);

// ### verification/opc_sink.sv
`timescale 1ns/100ps
// ----
// Consumer: refuses one cycle in four, and on demand
// ----
module opc_sink (
  input wire clk,
  input wire arst_n,
  input wire stall,
  input wire valid,
  input wire link,
  input wire [2:0] chan,
  input wire iq,
  input wire [15:0] data,
  output wire ready
);
  logic [20:0] q[$];
  logic [1:0] ph;
  assign ready = !stall && ph != 2'h3;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
      if (valid && ready) begin
        q.push_back({link, chan, iq, data});
      end
    end
  end
endmodule // opc_sink

// ### verification/output_port_configuration_bench.sv
`timescale 1ns/100ps
`include "opc_regs.vh"
module output_port_configuration_bench;
  logic clk, arst_n, psel, penable, pwrite, pci, stall, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [5:0] sv;
  logic [95:0] si, sq;
  logic [11:0] ra, rb;
  wire [31:0] prdata;
  wire [15:0] od;
  wire [2:0] oc;
  wire pready, pslverr, ov, ordy, oiq, olk, aen, ben, pco, poe;
  int err_total, checks, tick, c;
  localparam logic [31:0] MK [4] = '{32'hFF, 32'h3F, 32'hFF, 32'h07};
  opc_output_port u_dut (
    .CORE_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SRC_VALID(sv), .SRC_I(si),
    .SRC_Q(sq), .GAIN_A_SIGNAL_STRENGTH_WORD(ra), .GAIN_B_SIGNAL_STRENGTH_WORD(rb), .OUT_VALID(ov),
    .OUT_READY(ordy), .OUT_DATA(od), .OUT_IQ(oiq), .OUT_CHAN(oc),
    .OUT_LINK(olk), .PORT_A_LINK_EN(aen), .PORT_B_LINK_EN(ben),
    .PORT_CLK_IN(pci), .PORT_CLK_OUT(pco), .PORT_CLK_OE_N(poe)
  );
  opc_sink u_sink (
    .clk(clk), .arst_n(arst_n), .stall(stall), .valid(ov), .link(olk),
    .chan(oc), .iq(oiq), .data(od), .ready(ordy)
  );
  // ----
  // Clock, hang guard, shared tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    tick++;
    if (tick == 20000) begin
      err_total++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task src(input logic [5:0] m, input logic [15:0] i, input logic [15:0] q);
    @(posedge clk);
    sv <= m;
    for (int k = 0; k < 6; k++) begin
      si[16*k +: 16] <= i + k[15:0];
      sq[16*k +: 16] <= q + k[15:0];
    end
    @(posedge clk);
    sv <= 6'h00;
  endtask
  // Waits for w elements, then confirms the count
  task wt(input int w);
    c = 0;
    while (u_sink.q.size() < w && c < 2000) begin
      @(posedge clk);
      #1;
      c++;
    end
    check("count", u_sink.q.size(), w);
  endtask
  // Nothing more may arrive once a sequence is complete
  task quiet(input int w);
    repeat (40) @(posedge clk);
    check("quiet", u_sink.q.size(), w);
  endtask
  task el(input int k, input logic [2:0] ch, input logic [15:0] d);
    check("elem", {u_sink.q[k][19:17], u_sink.q[k][15:0]}, {ch, d});
  endtask
  task lk(input int k, input logic [2:0] ch, input logic [15:0] i, q);
    logic [15:0] b;
    for (int j = 0; j < 4; j++) begin
      b = j < 2 ? i >> (8 * j) : q >> (8 * j - 16);
      check("link", u_sink.q[k+j], {1'b1, ch, j < 2, 8'h00, b[7:0]});
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_regs;
    for (int k = 0; k < 4; k++) begin
      ap(0, `OPC_ADDR_LINK_A + 8'(4 * k), 32'h0);
      check("reset", rd, 32'h0);
      ap(1, `OPC_ADDR_LINK_A + 8'(4 * k), 32'hFFFFFFFF);
      ap(0, `OPC_ADDR_LINK_A + 8'(4 * k), 32'h0);
      check("rw", rd, MK[k]);
    end
    check("a_en", aen, 1'b1);
    ap(0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    check("slverr", er, 1'b1);
  endtask
  task t_par;
    ap(1, `OPC_ADDR_LINK_B, 32'h00);
    ap(1, `OPC_ADDR_PAR_B, 32'h0A);
    check("b_en", ben, 1'b0);
    u_sink.q.delete();
    src(6'h07, 16'h1230, 16'h4560);
    wt(4);
    check("p0", u_sink.q[0], {5'h01, 16'h1230});
    check("p1", u_sink.q[1], {5'h00, 16'h4560});
    check("p2", u_sink.q[2], {5'h05, 16'h1232});
    check("p3", u_sink.q[3], {5'h04, 16'h4562});
    quiet(4);
    ap(1, `OPC_ADDR_PAR_B, 32'h25);
    u_sink.q.delete();
    src(6'h30, 16'h5A3C, 16'hC396);
    wt(1);
    check("pack", u_sink.q[0], {5'h0B, 16'h5AC3});
    quiet(1);
  endtask
  task t_clk;
    logic p;
    for (int d = 1; d < 4; d++) begin
      ap(1, `OPC_ADDR_PCLK, {29'h0, 2'(d), 1'b1});
      c = 0;
      p = pco;
      repeat (32) begin
        @(posedge clk);
        if (pco !== p) c++;
        p = pco;
      end
      check("div", c, 32 >> (d - 1));
    end
    ap(1, `OPC_ADDR_PCLK, 32'h0);
    @(posedge clk);
    check("oe_n", poe, 1'b1);
    pci <= 1'b1;
    ap(0, `OPC_ADDR_STATUS, 32'h0);
    check("pclk_in", rd[11], 1'b1);
  endtask
  task t_rot;
    ap(1, `OPC_ADDR_LINK_B, 32'h82);
    u_sink.q.delete();
    stall <= 1'b1;
    src(6'h0F, 16'h1100, 16'h2200);
    repeat (40) @(posedge clk);
    check("full", {ov, 8'(u_sink.q.size())}, 9'h100);
    stall <= 1'b0;
    wt(16);
    for (int k = 0; k < 4; k++) lk(4 * k, 3'(k), 16'h1100 + 16'(k),
      16'h2200 + 16'(k));
    check("b_link", ben, 1'b1);
    ap(1, `OPC_ADDR_LINK_B, 32'h84);
    u_sink.q.delete();
    src(6'h0F, 16'h3300, 16'h4400);
    wt(8);
    lk(0, 3'h0, 16'h3300, 16'h4400);
    lk(4, 3'h1, 16'h3301, 16'h4401);
    quiet(8);
  endtask
  task t_gain;
    ap(1, `OPC_ADDR_LINK_B, 32'hE3);
    ra <= 12'h123;
    rb <= 12'hABC;
    u_sink.q.delete();
    src(6'h30, 16'h7700, 16'h8800);
    wt(1);
    check("delay", c >= 12 && c <= 18, 1'b1);
    wt(20);
    lk(0, 3'h5, 16'h7705, 16'h8805);
    el(4, 3'h5, 16'h00C0);
    el(5, 3'h5, 16'h00AB);
    for (int k = 6; k < 20; k++) el(k, 3'h5, 16'h0000);
    quiet(20);
    ap(1, `OPC_ADDR_LINK_B, 32'h81);
    u_sink.q.delete();
    src(6'h30, 16'h9900, 16'hAA00);
    wt(40);
    el(0, 3'h5, 16'h0005);
    el(20, 3'h4, 16'h0004);
    el(24, 3'h4, 16'h0030);
    ap(1, `OPC_ADDR_LINK_B, 32'h85);
    u_sink.q.delete();
    src(6'h30, 16'h9900, 16'hAA00);
    wt(8);
    quiet(8);
  endtask
  initial begin
    {arst_n, psel, penable, pwrite, pci, stall} = 6'h00;
    {paddr, pwdata, sv, si, sq, ra, rb} = '0;
    err_total = 0;
    checks = 0;
    tick = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_par;
    t_clk;
    t_rot;
    t_gain;
    give_verdict;
  end
endmodule // output_port_configuration_bench
